// File: cfs_pkg.sv
// Purpose: constants for the configuration fuse decoder and reset sequencer
// Assumes: 50 MHz aclk, fuse words stable while the device is held in reset
// Notes:   register offsets are byte addresses of aligned 32-bit words
package cfs_pkg;
  localparam int          CLK_HZ        = 50_000_000;
  localparam int          REG_START_NS  = 20_000;
  localparam int          REG_START_CYC = (REG_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          POWER_UP_MS   = 2;
  localparam int          FAIL_SAFE_US  = 100;
  localparam int          POWER_UP_CYC  = POWER_UP_MS * (CLK_HZ / 1000);
  localparam int          FAIL_SAFE_CYC = FAIL_SAFE_US * (CLK_HZ / 1_000_000);
  // register map
  localparam logic [7:0]  ADDR_OSC      = 8'h00;
  localparam logic [7:0]  ADDR_WDT      = 8'h04;
  localparam logic [7:0]  ADDR_POR      = 8'h08;
  localparam logic [7:0]  ADDR_DBG      = 8'h0C;
  localparam logic [7:0]  ADDR_RST_CTRL = 8'h10;
  localparam logic [7:0]  ADDR_STATUS   = 8'h14;
  localparam logic [7:0]  ADDR_REMAP    = 8'h18;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;
  // oscillator_config fields
  localparam int          CKSM_HI       = 7;
  localparam int          CKSM_LO       = 6;
  localparam int          REMAP_LOCK    = 5;
  localparam int          OSC_PIN_FN    = 2;
  localparam logic [1:0]  POSC_OFF      = 2'h3;
  localparam logic [1:0]  POSC_HS       = 2'h2;
  localparam logic [1:0]  POSC_XT       = 2'h1;
  // watchdog_config fields
  localparam int          WDT_FORCE     = 7;
  localparam int          WDT_WIN_DIS   = 6;
  localparam int          WDT_PRE       = 4;
  localparam logic [7:0]  PRE_DIV_HI    = 8'h80;
  localparam logic [7:0]  PRE_DIV_LO    = 8'h20;
  // power_on_config and debug_config fields
  localparam int          TWO_WIRE_ALT  = 4;
  localparam logic [2:0]  POWER_UP_OFF  = 3'h0;
  localparam int          BKG_DEBUG     = 6;
  localparam int          EMU_ENABLE    = 5;
  // initial oscillator select codes
  localparam logic [2:0]  INIT_PRI_PLL  = 3'h3;
  localparam logic [2:0]  INIT_PRI      = 3'h2;
  localparam logic [2:0]  INIT_FRC_PLL  = 3'h1;
  // reset_control_register and status bits
  localparam int          RST_BOR       = 1;
  localparam int          RST_SWDT      = 5;
  localparam int          ST_RELEASED   = 0;
  localparam int          ST_CLOCK      = 1;
  localparam int          ST_EXEC       = 2;
  localparam int          ST_REMAPPED   = 3;
  localparam int          ST_SEL_LO     = 4;
  // synchroniser lanes
  localparam int          SY_RESUME     = 0;
  localparam int          SY_PLL        = 1;
  localparam int          SY_OSC_START  = 2;
  localparam int          SY_BOR        = 3;
  localparam int          SY_POR        = 4;
  typedef enum logic [1:0] {SEQ_HOLD, SEQ_REGULATOR, SEQ_WAIT, SEQ_RUN} seq_state_t;
endpackage

// File: config_fuse_reset_sequencer.sv
// Purpose: decode configuration fuses and sequence internal reset release
// Assumes: analog detectors and oscillator status arrive asynchronously
// Notes:   fuses are captured while held in reset and frozen afterwards
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - upper switch-mode bit blocks switching and fail-safe; 01 switch only; 00 both.
// - with remap lock set only one pin remap write is accepted.
// - outside crystal modes the pin function bit selects clock out or I/O.
// - oscillator mode 11 off, 10 HS crystal, 01 XT crystal, 00 external.
// - force enable keeps watchdog and its RC clock running, ignoring software.
// - window disable 0 gives windowed watchdog, 1 non-windowed.
// - prescale bit 1 divides by 128, 0 by 32.
// - postscale code n gives ratio two to the power n.
// - two-wire bit 1 uses primary pins, 0 alternate pins.
// - power-up code 111 is 128 ms halving to 2 ms; 000 off.
// - background debug bit 1 resets in user mode, 0 debug mode.
// - emulator bit 1 resets in operational mode, 0 emulation mode.
// - channel 11 pair 1, 10 pair 2, 01 pair 3, 00 reserved.
// - execution stays off for 20 us after power-on and each resume.
// - brown-out resets the device; clock source comes from the fuses.
// - with a crystal selected the clock waits for the start-up timer.
// - power-up delay runs alongside oscillator wait; fail-safe delay if zero with crystal.
// - brown-out sets status bit 1 of the reset control register.
// - brown-out detection works in every state including sleep and idle.
// - select 011 primary with PLL, 010 primary, 000 fast RC.
// - software watchdog bit 5 enables watchdog; every device reset clears it.
module config_fuse_reset_sequencer
#(
  parameter int POWER_UP_BASE_CYCLES = cfs_pkg::POWER_UP_CYC,
  parameter int FAIL_SAFE_CYCLES     = cfs_pkg::FAIL_SAFE_CYC
)
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  // fuse words
  input  wire logic [7:0]  oscillator_fuses,
  input  wire logic [7:0]  watchdog_fuses,
  input  wire logic [7:0]  power_on_fuses,
  input  wire logic [7:0]  debug_fuses,
  input  wire logic [2:0]  initial_oscillator_select,
  // asynchronous detectors and status
  input  wire logic        power_on_detect,
  input  wire logic        brown_out_detect,
  input  wire logic        oscillator_start_done,
  input  wire logic        pll_lock,
  input  wire logic        power_resume,
  // sequencing outputs
  output logic             core_reset_n,
  output logic             sys_clock_enable,
  output logic             code_exec_enable,
  // decoded configuration and pin remap map
  output logic             clock_switch_enable,
  output logic             fail_safe_enable,
  output logic             osc_clock_out,
  output logic             primary_osc_enable,
  output logic             osc_mode_hs,
  output logic             osc_mode_xt,
  output logic             watchdog_enable,
  output logic             low_power_rc_enable,
  output logic             watchdog_windowed,
  output logic [7:0]       watchdog_prescale_div,
  output logic [3:0]       watchdog_postscale_log2,
  output logic             two_wire_primary_pins,
  output logic             debug_mode,
  output logic             emulation_mode,
  output logic [1:0]       debug_pair,
  output logic [7:0]       pin_remap_map
);
  import cfs_pkg::*;

  typedef struct packed {
    seq_state_t  st;
    logic        resuming;
    logic [31:0] delay;
    logic [4:0]  s1;
    logic [4:0]  s2;
    logic [4:0]  s3;
    logic [4:0]  flt;
    logic        bor_prev;
    logic        resume_prev;
    logic [7:0]  oscillator_config;
    logic [7:0]  watchdog_config;
    logic [7:0]  power_on_config;
    logic [7:0]  debug_config;
    logic [2:0]  init_sel;
    logic        bor_status;
    logic        swdt;
    logic        remap_used;
    logic [7:0]  remap_map;
    logic        core_reset_n;
    logic        clk_en;
    logic        exec_en;
    logic        cksw;
    logic        fscm;
    logic        osc_out;
    logic        posc_en;
    logic        hs;
    logic        xt;
    logic        wdt_en;
    logic        wdt_win;
    logic [7:0]  pre_div;
    logic [3:0]  post_log2;
    logic        i2c_pri;
    logic        dbg;
    logic        emu;
    logic [1:0]  pair;
    logic        awready;
    logic        wready;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } state_t;

  state_t s;
  state_t n;
  logic   bor_evt;
  logic   resume_evt;
  logic   crystal;
  logic   need_start;
  logic   need_pll;
  logic   waits_done;
  logic   remap_wr;
  logic   delay_zero;
  logic [2:0]  delay_code;
  logic [31:0] delay_load;

  if (POWER_UP_BASE_CYCLES < 1 || FAIL_SAFE_CYCLES < 1 ||
      longint'(POWER_UP_BASE_CYCLES) * 64 >= 64'h1_0000_0000)
  begin : g_bad_param
    $error("delay parameters out of range");
  end

  assign crystal    = (s.oscillator_config[1:0] == POSC_HS) ||
                      (s.oscillator_config[1:0] == POSC_XT);
  // primary source needs its start-up timer in a crystal mode
  assign need_start = ((s.init_sel == INIT_PRI_PLL) || (s.init_sel == INIT_PRI)) && crystal;
  assign need_pll   = (s.init_sel == INIT_PRI_PLL) || (s.init_sel == INIT_FRC_PLL);
  assign waits_done = (!need_start || s.flt[SY_OSC_START]) && (!need_pll || s.flt[SY_PLL]);
  assign delay_code = s.power_on_config[2:0];
  assign delay_zero = (s.delay == 32'h0);
  assign remap_wr   = s.aw_have && s.w_have && !s.bvalid &&
                      ({s.aw_addr[7:2], 2'h0} == ADDR_REMAP) && s.w_strb[0];

  always_comb
  begin
    delay_load = 32'h0;
    if (delay_code != POWER_UP_OFF)
    begin
      delay_load = 32'(POWER_UP_BASE_CYCLES) << (delay_code - 3'h1);
    end
    else if (crystal)
    begin
      delay_load = 32'(FAIL_SAFE_CYCLES);
    end
  end

  always_comb
  begin
    n = s;
    // three-stage synchronisers, value taken when stages two and three agree
    n.s1 = {power_on_detect, brown_out_detect, oscillator_start_done, pll_lock,
            power_resume};
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.flt = (~(s.s2 ^ s.s3) & s.s3) | ((s.s2 ^ s.s3) & s.flt);
    n.bor_prev = s.flt[SY_BOR];
    n.resume_prev = s.flt[SY_RESUME];
    bor_evt = s.flt[SY_BOR] && !s.bor_prev;
    resume_evt = s.flt[SY_RESUME] && !s.resume_prev;

    // axi write path
    if (awvalid && s.awready)
    begin
      n.aw_have = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      n.w_have = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (s.bvalid && bready)
    begin
      n.bvalid = 1'b0;
    end
    if (s.aw_have && s.w_have && !s.bvalid)
    begin
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case ({s.aw_addr[7:2], 2'h0})
        ADDR_OSC, ADDR_WDT, ADDR_POR, ADDR_DBG, ADDR_STATUS:
        begin
          n.bresp = RESP_OKAY;
        end
        ADDR_RST_CTRL:
        begin
          if (s.w_strb[0])
          begin
            n.swdt = s.w_data[RST_SWDT];
            if (s.w_data[RST_BOR])
            begin
              n.bor_status = 1'b0;
            end
          end
        end
        ADDR_REMAP:
        begin
          if (s.w_strb[0])
          begin
            if (!s.oscillator_config[REMAP_LOCK] || !s.remap_used)
            begin
              n.remap_map = s.w_data[7:0];
              n.remap_used = 1'b1;
            end
            else
            begin
              n.bresp = RESP_SLVERR;
            end
          end
        end
        default:
        begin
          n.bresp = RESP_DECERR;
        end
      endcase
    end

    // axi read path
    if (s.rvalid && rready)
    begin
      n.rvalid = 1'b0;
    end
    if (arvalid && s.arready)
    begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0;
      case ({araddr[7:2], 2'h0})
        ADDR_OSC:    n.rdata[7:0] = s.oscillator_config;
        ADDR_WDT:    n.rdata[7:0] = s.watchdog_config;
        ADDR_POR:    n.rdata[7:0] = s.power_on_config;
        ADDR_DBG:    n.rdata[7:0] = s.debug_config;
        ADDR_RST_CTRL:
        begin
          n.rdata[RST_SWDT] = s.swdt;
          n.rdata[RST_BOR] = s.bor_status;
        end
        ADDR_STATUS:
        begin
          n.rdata[ST_RELEASED] = s.core_reset_n;
          n.rdata[ST_CLOCK] = s.clk_en;
          n.rdata[ST_EXEC] = s.exec_en;
          n.rdata[ST_REMAPPED] = s.remap_used;
          n.rdata[ST_SEL_LO +: 3] = s.init_sel;
        end
        ADDR_REMAP:  n.rdata[7:0] = s.remap_map;
        default:     n.rresp = RESP_DECERR;
      endcase
    end

    // reset sequencer
    case (s.st)
      SEQ_HOLD:
      begin
        n.core_reset_n = 1'b0;
        n.clk_en = 1'b0;
        n.exec_en = 1'b0;
        n.swdt = 1'b0;
        n.remap_used = 1'b0;
        n.resuming = 1'b0;
        n.st = SEQ_REGULATOR;
        n.delay = 32'(REG_START_CYC);
      end
      SEQ_REGULATOR:
      begin
        n.exec_en = 1'b0;
        if (s.delay > 32'h1)
        begin
          n.delay = s.delay - 32'h1;
        end
        else if (s.resuming)
        begin
          n.st = SEQ_RUN;
          n.exec_en = 1'b1;
          n.resuming = 1'b0;
        end
        else
        begin
          n.st = SEQ_WAIT;
          n.delay = delay_load;
        end
      end
      SEQ_WAIT:
      begin
        n.clk_en = waits_done;
        if (!delay_zero)
        begin
          n.delay = s.delay - 32'h1;
        end
        else if (waits_done)
        begin
          n.st = SEQ_RUN;
          n.core_reset_n = 1'b1;
          n.exec_en = 1'b1;
        end
      end
      SEQ_RUN:
      begin
        if (resume_evt)
        begin
          n.st = SEQ_REGULATOR;
          n.resuming = 1'b1;
          n.exec_en = 1'b0;
          n.delay = 32'(REG_START_CYC);
        end
      end
      default:
      begin
        n.st = SEQ_HOLD;
      end
    endcase

    // detectors hold the device in reset from any state
    if (s.flt[SY_POR] || s.flt[SY_BOR])
    begin
      n.st = SEQ_HOLD;
      n.core_reset_n = 1'b0;
      n.clk_en = 1'b0;
      n.exec_en = 1'b0;
    end
    if (bor_evt)
    begin
      n.bor_status = 1'b1;
    end

    // fuses follow their inputs only while the device is in reset
    if (s.st == SEQ_HOLD || (s.st == SEQ_REGULATOR && !s.resuming))
    begin
      n.oscillator_config = oscillator_fuses;
      n.watchdog_config = watchdog_fuses;
      n.power_on_config = power_on_fuses;
      n.debug_config = debug_fuses;
      n.init_sel = initial_oscillator_select;
    end

    // decode of the captured fuses
    n.cksw = !s.oscillator_config[CKSM_HI];
    n.fscm = !s.oscillator_config[CKSM_HI] && !s.oscillator_config[CKSM_LO];
    n.posc_en = (s.oscillator_config[1:0] != POSC_OFF);
    n.hs = (s.oscillator_config[1:0] == POSC_HS);
    n.xt = (s.oscillator_config[1:0] == POSC_XT);
    n.osc_out = !crystal && s.oscillator_config[OSC_PIN_FN];
    n.wdt_en = s.watchdog_config[WDT_FORCE] || s.swdt;
    n.wdt_win = !s.watchdog_config[WDT_WIN_DIS];
    n.pre_div = s.watchdog_config[WDT_PRE] ? PRE_DIV_HI : PRE_DIV_LO;
    n.post_log2 = s.watchdog_config[3:0];
    n.i2c_pri = s.power_on_config[TWO_WIRE_ALT];
    n.dbg = !s.debug_config[BKG_DEBUG];
    n.emu = !s.debug_config[EMU_ENABLE];
    n.pair = 2'h0 - s.debug_config[1:0];

    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    n.arready = !n.rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence q_reg_entry;
    (s.st != SEQ_REGULATOR) ##1 (s.st == SEQ_REGULATOR);
  endsequence
  sequence q_exec_off;
    !s.exec_en [*8];
  endsequence

  property p_reg_hold;
    q_reg_entry |=> q_exec_off;
  endproperty
  a_reg_hold: assert property (p_reg_hold) else $error("execution during regulator start");

  property p_bor_flag;
    (s.flt[SY_BOR] && !s.bor_prev) |=> s.bor_status && (s.st == SEQ_HOLD);
  endproperty
  a_bor_flag: assert property (p_bor_flag) else $error("brown-out not flagged");

  property p_swdt_clear;
    (s.st == SEQ_HOLD) |=> !s.swdt ##1 !s.wdt_en || s.watchdog_config[WDT_FORCE];
  endproperty
  a_swdt_clear: assert property (p_swdt_clear) else $error("software watchdog not cleared");

  property p_force_wdt;
    s.watchdog_config[WDT_FORCE] |=> watchdog_enable && low_power_rc_enable;
  endproperty
  a_force_wdt: assert property (p_force_wdt) else $error("forced watchdog off");

  property p_cksm;
    s.oscillator_config[CKSM_HI] |=> !clock_switch_enable && !fail_safe_enable;
  endproperty
  a_cksm: assert property (p_cksm) else $error("switching allowed when blocked");

  property p_release;
    $rose(s.core_reset_n) |-> $past(delay_zero) && $past(waits_done);
  endproperty
  a_release: assert property (p_release) else $error("reset released early");

  property p_start_hold;
    (s.st == SEQ_WAIT && need_start && !s.flt[SY_OSC_START] && !s.flt[SY_POR] &&
     !s.flt[SY_BOR]) |=> !sys_clock_enable;
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("clock before start-up timer");

  property p_pll_hold;
    (s.st == SEQ_WAIT && need_pll && !s.flt[SY_PLL]) |=> !sys_clock_enable;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("clock before pll lock");

  property p_remap_lock;
    (remap_wr && s.oscillator_config[REMAP_LOCK] && s.remap_used) |=>
      $stable(pin_remap_map) && (bresp == RESP_SLVERR);
  endproperty
  a_remap_lock: assert property (p_remap_lock) else $error("locked remap accepted");

  property p_fuse_frozen;
    (s.st == SEQ_RUN && !s.flt[SY_POR] && !s.flt[SY_BOR]) |=>
      $stable({s.oscillator_config, s.watchdog_config, s.power_on_config, s.debug_config,
               s.init_sel});
  endproperty
  a_fuse_frozen: assert property (p_fuse_frozen) else $error("fuse changed while running");

  assign awready                 = s.awready;
  assign wready                  = s.wready;
  assign bvalid                  = s.bvalid;
  assign bresp                   = s.bresp;
  assign arready                 = s.arready;
  assign rvalid                  = s.rvalid;
  assign rdata                   = s.rdata;
  assign rresp                   = s.rresp;
  assign core_reset_n            = s.core_reset_n;
  assign sys_clock_enable        = s.clk_en;
  assign code_exec_enable        = s.exec_en;
  assign clock_switch_enable     = s.cksw;
  assign fail_safe_enable        = s.fscm;
  assign osc_clock_out           = s.osc_out;
  assign primary_osc_enable      = s.posc_en;
  assign osc_mode_hs             = s.hs;
  assign osc_mode_xt             = s.xt;
  assign watchdog_enable         = s.wdt_en;
  assign low_power_rc_enable     = s.wdt_en;
  assign watchdog_windowed       = s.wdt_win;
  assign watchdog_prescale_div   = s.pre_div;
  assign watchdog_postscale_log2 = s.post_log2;
  assign two_wire_primary_pins   = s.i2c_pri;
  assign debug_mode              = s.dbg;
  assign emulation_mode          = s.emu;
  assign debug_pair              = s.pair;
  assign pin_remap_map           = s.remap_map;
endmodule

// File: test_config_fuse_reset_sequencer.sv
// Purpose: self-checking bench for the fuse decoder and reset sequencer
// Assumes: 50 MHz aclk, short power-up base of 4 and fail-safe of 3 cycles
// Notes:   bus handshakes are judged at mid-cycle, ahead of the next rising edge
`timescale 1ns/1ps
module test_config_fuse_reset_sequencer;
  import cfs_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [7:0]  oscillator_fuses = 0, watchdog_fuses = 0, power_on_fuses = 0, debug_fuses = 0;
  logic [2:0]  initial_oscillator_select = 0;
  logic        power_on_detect = 0, brown_out_detect = 0;
  logic        oscillator_start_done = 0, pll_lock = 0, power_resume = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, debug_pair;
  logic [31:0] rdata;
  logic        core_reset_n, sys_clock_enable, code_exec_enable;
  logic        clock_switch_enable, fail_safe_enable, osc_clock_out, primary_osc_enable;
  logic        osc_mode_hs, osc_mode_xt, watchdog_enable, low_power_rc_enable;
  logic        watchdog_windowed, two_wire_primary_pins, debug_mode, emulation_mode;
  logic [7:0]  watchdog_prescale_div, pin_remap_map;
  logic [3:0]  watchdog_postscale_log2;
  int          err_count = 0, cmp_count = 0, cyc = 0;

  config_fuse_reset_sequencer #(.POWER_UP_BASE_CYCLES(4), .FAIL_SAFE_CYCLES(3))
    config_fuse_reset_sequencer_i (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp,
    .oscillator_fuses, .watchdog_fuses, .power_on_fuses, .debug_fuses,
    .initial_oscillator_select, .power_on_detect, .brown_out_detect,
    .oscillator_start_done, .pll_lock, .power_resume, .core_reset_n, .sys_clock_enable,
    .code_exec_enable, .clock_switch_enable, .fail_safe_enable, .osc_clock_out,
    .primary_osc_enable, .osc_mode_hs, .osc_mode_xt, .watchdog_enable,
    .low_power_rc_enable, .watchdog_windowed, .watchdog_prescale_div,
    .watchdog_postscale_log2, .two_wire_primary_pins, .debug_mode, .emulation_mode,
    .debug_pair, .pin_remap_map);

  always #10 aclk = ~aclk;

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit an, wn, bn;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bn)
    begin
      @(negedge aclk);
      an = awvalid && awready;
      wn = wvalid && wready;
      bn = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (an) awvalid <= 1'b0;
      if (wn) wvalid <= 1'b0;
      if (bn) bready <= 1'b0;
    end
    chk("bresp", er, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit an, rn;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rn)
    begin
      @(negedge aclk);
      an = arvalid && arready;
      rn = rvalid && rready;
      if (rn) chk("rdata", ed, rdata);
      if (rn) chk("rresp", er, rresp);
      @(posedge aclk);
      if (an) arvalid <= 1'b0;
      if (rn) rready <= 1'b0;
    end
  endtask

  task automatic dec(input logic [13:0] f, input logic [11:0] dp);
    @(negedge aclk);
    chk("flags", f, {clock_switch_enable, fail_safe_enable, osc_clock_out,
        primary_osc_enable, osc_mode_hs, osc_mode_xt, watchdog_enable, low_power_rc_enable,
        watchdog_windowed, two_wire_primary_pins, debug_mode, emulation_mode, debug_pair});
    chk("wdt scale", dp, {watchdog_prescale_div, watchdog_postscale_log2});
  endtask

  // hold: keep oscillator start and lock low until checked, dly: expected wait
  task automatic boot(input logic [7:0] o, w, p, d, input logic [2:0] s,
                      input bit bo, hold, input int dly);
    int n;
    int e;
    bit rel;
    @(posedge aclk);
    oscillator_fuses <= o;
    watchdog_fuses <= w;
    power_on_fuses <= p;
    debug_fuses <= d;
    initial_oscillator_select <= s;
    oscillator_start_done <= !hold;
    pll_lock <= !hold;
    brown_out_detect <= bo;
    power_on_detect <= !bo;
    repeat (8) @(posedge aclk);
    brown_out_detect <= 1'b0;
    power_on_detect <= 1'b0;
    while (!rel && n < 2000)
    begin
      @(negedge aclk);
      n++;
      rel = core_reset_n === 1'b1;
      if (code_exec_enable === 1'b1 && e == 0) e = n;
      if (hold && n == 1200)
      begin
        chk("held", 0, {core_reset_n, sys_clock_enable});
        @(posedge aclk);
        oscillator_start_done <= 1'b1;
        pll_lock <= 1'b1;
      end
    end
    if (e == 0) e = n;
    chk("exec delay", 1, e >= 1000);
    if (hold) chk("release", 1, n > 1200 && n <= 1212);
    else chk("release", 1, n >= 1000 + dly && n <= 1012 + dly);
    chk("clock on", 1, sys_clock_enable);
  endtask

  initial
  begin
    int n;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    boot(8'h25, 8'h1E, 8'h12, 8'h42, 3'h2, 0, 1, 0);
    dec(14'b11010100110110, 12'h80E);
    rd(ADDR_OSC, 32'h25, RESP_OKAY);
    rd(ADDR_WDT, 32'h1E, RESP_OKAY);
    rd(ADDR_POR, 32'h12, RESP_OKAY);
    rd(ADDR_DBG, 32'h42, RESP_OKAY);
    wr(ADDR_OSC, 32'hFF, RESP_OKAY);
    rd(ADDR_OSC, 32'h25, RESP_OKAY);
    rd(8'h1C, 32'h0, RESP_DECERR);
    wr(8'h1C, 32'h1, RESP_DECERR);
    rd(ADDR_STATUS, 32'h27, RESP_OKAY);
    rd(ADDR_RST_CTRL, 32'h0, RESP_OKAY);
    wr(ADDR_RST_CTRL, 32'h20, RESP_OKAY);
    rd(ADDR_RST_CTRL, 32'h20, RESP_OKAY);
    wr(ADDR_REMAP, 32'h5A, RESP_OKAY);
    wr(ADDR_REMAP, 32'hA5, RESP_SLVERR);
    rd(ADDR_REMAP, 32'h5A, RESP_OKAY);
    @(negedge aclk);
    chk("remap", 32'h5A, pin_remap_map);
    @(posedge aclk);
    oscillator_fuses <= 8'h83;
    watchdog_fuses <= 8'h00;
    power_on_fuses <= 8'h07;
    debug_fuses <= 8'h00;
    repeat (4) @(posedge aclk);
    dec(14'b11010111110110, 12'h80E);
    @(posedge aclk);
    power_resume <= 1'b1;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    chk("resume", 32'h2, {core_reset_n, code_exec_enable});
    while (code_exec_enable !== 1'b1 && n < 1200)
    begin
      @(negedge aclk);
      n++;
    end
    chk("resume time", 1, n >= 980 && n <= 1000);
    @(posedge aclk);
    power_resume <= 1'b0;
    boot(8'h44, 8'hCF, 8'h00, 8'h63, 3'h3, 1, 1, 0);
    dec(14'b10110011000001, 12'h20F);
    rd(ADDR_RST_CTRL, 32'h2, RESP_OKAY);
    wr(ADDR_RST_CTRL, 32'h2, RESP_OKAY);
    rd(ADDR_RST_CTRL, 32'h0, RESP_OKAY);
    dec(14'b10110011000001, 12'h20F);
    wr(ADDR_REMAP, 32'h11, RESP_OKAY);
    wr(ADDR_REMAP, 32'h22, RESP_OKAY);
    rd(ADDR_REMAP, 32'h22, RESP_OKAY);
    boot(8'h82, 8'h00, 8'h10, 8'h01, 3'h0, 0, 0, 3);
    dec(14'b00011000111111, 12'h200);
    boot(8'hC3, 8'h10, 8'h17, 8'h00, 3'h7, 0, 0, 256);
    dec(14'b00000000111100, 12'h800);
    tally_and_finish;
  end
endmodule
